// >>> hdl/mem_ctrl_defs.svh
// constants for the static memory controller: decode nibbles, traps,
// beat masks and reset values; included by bare name, definitions only
`ifndef MEM_CTRL_DEFS_SVH
`define MEM_CTRL_DEFS_SVH

// =====================================================
// address decode on addr[31:28]
`define MC_NIB_BOOT0      4'h0
`define MC_NIB_BOOT1      4'h1
`define MC_NIB_IO_LO      4'h2
`define MC_NIB_IO_HI      4'h3
`define MC_NIB_RAM_LO     4'h4
`define MC_NIB_RAM_HI     4'h5
`define MC_NIB_BANK4      4'h6
`define MC_NIB_DYN_FIRST  4'h6
`define MC_NIB_DYN_LAST   4'h7
`define MC_BANK_MIN_SHIFT 5'h0d
`define MC_BANK_NONE      3'h7
`define MC_BANK_FOUR      3'h4

// =====================================================
// trap codes
`define MC_TRAP_FETCH     8'h01
`define MC_TRAP_LOAD      8'h09
`define MC_TRAP_WRITE     8'h2b

// =====================================================
// access shape
`define MC_READ_CYCLES    6'h02
`define MC_WRITE_CYCLES   6'h01
`define MC_MASK_WIDE      5'h01
`define MC_MASK_NARROW    5'h0f
`define MC_MASK_EDAC      5'h1f
`define MC_CHECK_BEAT     3'h4
`define MC_NO_BEAT        3'h5
`define MC_FULL_WORD      4'hf
`define MC_NARROW_LANE    4'h8

// =====================================================
// reset values
`define MC_BOOT_WS_RESET  4'hf

`endif

// >>> hdl/mem_ctrl_pkg.sv
// types for the static memory controller
// assumes mem_ctrl_defs.svh holds the decode, trap, shape and reset constants
`include "mem_ctrl_defs.svh"
package mem_ctrl_pkg;

  typedef enum logic [4:0]
  {
    ST_IDLE  = 5'h01,
    ST_LEAD  = 5'h02,
    ST_DATA  = 5'h04,
    ST_READY = 5'h08,
    ST_TRAIL = 5'h10
  } seq_state_t;

  typedef enum logic [1:0]
  {
    AREA_BOOT0 = 2'h0,
    AREA_BOOT1 = 2'h1,
    AREA_IO    = 2'h2,
    AREA_RAM   = 2'h3
  } area_t;

  typedef struct packed
  {
    logic [3:0] boot_read_ws;
    logic [3:0] boot_write_ws;
    logic       boot_write_enable;
    logic       boot_width_8;
    logic       boot_edac_enable;
    logic       boot_ready_enable;
    logic       io_enable;
    logic       io_width_8;
    logic [3:0] io_ws;
    logic       io_ready_enable;
    logic       ram_width_8;
    logic [3:0] ram_bank_size;
    logic [1:0] ram_read_ws;
    logic [1:0] ram_write_ws;
    logic       ram_rmw;
    logic       ram_edac_enable;
    logic       ram_ready_enable;
    logic       sdram_enable;
  } cfg_t;

  typedef struct packed
  {
    seq_state_t  state;
    area_t       area;
    logic [2:0]  bank;
    logic [31:0] addr;
    logic        wr, fetch;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic [7:0]  wcbits;
    logic [31:0] rdata;
    logic [7:0]  cbits;
    logic [5:0]  cnt;
    logic [2:0]  beat;
    logic [4:0]  mask;
    logic        narrow, rmw, rdy_ok, ready, done, trap;
    logic [7:0]  code;
    logic        sdram;
  } seq_t;

  typedef struct packed
  {
    logic [27:0] addr;
    logic [31:0] data;
    logic        data_oe;
    logic [7:0]  cb;
    logic        cb_oe;
    logic [1:0]  boot_cs_n;
    logic        io_cs_n;
    logic [4:0]  bank_cs_n;
    logic [3:0]  bank_oe_n;
    logic        oe_n, rd, we_n;
    logic [3:0]  lane_n;
  } pin_t;

  function automatic logic [4:0] beat_mask(input logic narrow, input logic edac,
                                           input logic by_lane, input logic [3:0] be);
    if (!narrow)
      beat_mask = `MC_MASK_WIDE;
    else if (by_lane)
      beat_mask = {1'b0, be[0], be[1], be[2], be[3]};
    else if (edac)
      beat_mask = `MC_MASK_EDAC;
    else
      beat_mask = `MC_MASK_NARROW;
  endfunction

  function automatic logic [2:0] next_beat(input logic [4:0] mask, input logic [2:0] from);
    next_beat = `MC_NO_BEAT;
    for (int i = 4; i >= 0; i--)
      if (mask[i] && (3'(i) >= from))
        next_beat = 3'(i);
  endfunction

  function automatic logic [5:0] data_len(input area_t area, input logic wr,
                                          input logic [2:0] bank, input cfg_t c);
    logic [5:0] ws;
    ws = 6'h00;
    case (area)
      AREA_IO:
        ws = {2'h0, c.io_ws};
      AREA_RAM:
        ws = {4'h0, wr ? c.ram_write_ws : c.ram_read_ws};
      default:
        ws = {1'b0, wr ? c.boot_write_ws : c.boot_read_ws, 1'b0};
    endcase
    // counts down to zero, so one less than the cycle total
    data_len = (wr ? `MC_WRITE_CYCLES : `MC_READ_CYCLES) + ws - 6'h01;
  endfunction

  function automatic logic [7:0] fault_code(input logic wr, input logic fetch);
    fault_code = wr ? `MC_TRAP_WRITE : (fetch ? `MC_TRAP_FETCH : `MC_TRAP_LOAD);
  endfunction

  function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [1:0] i);
    lane_byte = w[8'(31 - 8 * i) -: 8];
  endfunction

endpackage

// >>> hdl/prom_io_sram_memory_controller.sv
// boot memory, memory-mapped i/o and static ram sequencer with decode
// assumes one request at a time from the internal bus; edac codec outside
`timescale 1ns/1ps
`include "mem_ctrl_defs.svh"
`default_nettype none

module prom_io_sram_memory_controller
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cfg_load,
  input  wire logic [3:0]  cfg_boot_read_ws,
  input  wire logic [3:0]  cfg_boot_write_ws,
  input  wire logic        cfg_boot_write_enable,
  input  wire logic        cfg_boot_width_8,
  input  wire logic        boot_edac_enable,
  input  wire logic        cfg_boot_ready_enable,
  input  wire logic        cfg_io_enable,
  input  wire logic        cfg_io_width_8,
  input  wire logic [3:0]  cfg_io_ws,
  input  wire logic        cfg_io_ready_enable,
  input  wire logic        cfg_ram_width_8,
  input  wire logic [3:0]  cfg_ram_bank_size,
  input  wire logic [1:0]  cfg_ram_read_ws,
  input  wire logic [1:0]  cfg_ram_write_ws,
  input  wire logic        cfg_ram_rmw,
  input  wire logic        ram_edac_enable,
  input  wire logic        cfg_ram_ready_enable,
  input  wire logic        cfg_sdram_enable,
  input  wire logic        req_valid,
  input  wire logic [31:0] req_addr,
  input  wire logic        req_write,
  input  wire logic        req_fetch,
  input  wire logic [3:0]  req_byte_en,
  input  wire logic [31:0] req_wdata,
  input  wire logic [7:0]  req_check_bits,
  output logic             req_ready,
  output logic             resp_done,
  output logic             resp_trap,
  output logic [7:0]       resp_trap_code,
  output logic [31:0]      resp_rdata,
  output logic [7:0]       resp_check_bits,
  output logic             sdram_request,
  output logic [27:0]      addr_out,
  input  wire logic [31:0] data_in,
  output logic [31:0]      data_out,
  output logic             data_oe,
  input  wire logic [7:0]  check_bit_lines_in,
  output logic [7:0]       check_bit_lines_out,
  output logic             check_bit_lines_oe,
  output logic [1:0]       boot_chip_select_n,
  output logic             io_chip_select_n,
  output logic [4:0]       static_bank_select_n,
  output logic [3:0]       static_bank_output_enable_n,
  output logic             output_enable_n,
  output logic             read_strobe,
  output logic             write_strobe_n,
  output logic [3:0]       byte_lane_write_strobe_n,
  input  wire logic        external_ready_n
);

  // =====================================================
  // configuration
  mem_ctrl_pkg::cfg_t cfg_ff;
  mem_ctrl_pkg::cfg_t nxt_cfg;

  always_comb
  begin
    nxt_cfg = cfg_ff;
    if (cfg_load)
      nxt_cfg = '{cfg_boot_read_ws, cfg_boot_write_ws, cfg_boot_write_enable, cfg_boot_width_8,
                  boot_edac_enable, cfg_boot_ready_enable, cfg_io_enable, cfg_io_width_8, cfg_io_ws,
                  cfg_io_ready_enable, cfg_ram_width_8, cfg_ram_bank_size, cfg_ram_read_ws,
                  cfg_ram_write_ws, cfg_ram_rmw, ram_edac_enable, cfg_ram_ready_enable,
                  cfg_sdram_enable};
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_ff               <= '0;
      cfg_ff.boot_read_ws  <= `MC_BOOT_WS_RESET;
      cfg_ff.boot_write_ws <= `MC_BOOT_WS_RESET;
    end
    else
      cfg_ff <= nxt_cfg;
  end

  // =====================================================
  // ready synchroniser: a change counts once stages two and three agree
  logic rdy_s1_ff, rdy_s2_ff, rdy_s3_ff, rdy_ff;
  logic nxt_rdy;

  always_comb
  begin
    nxt_rdy = rdy_ff;
    if (rdy_s2_ff == rdy_s3_ff)
      nxt_rdy = !rdy_s3_ff;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdy_s1_ff <= 1'b1;
      rdy_s2_ff <= 1'b1;
      rdy_s3_ff <= 1'b1;
      rdy_ff    <= 1'b0;
    end
    else
    begin
      rdy_s1_ff <= external_ready_n;
      rdy_s2_ff <= rdy_s1_ff;
      rdy_s3_ff <= rdy_s2_ff;
      rdy_ff    <= nxt_rdy;
    end
  end

  // =====================================================
  // access sequencer
  mem_ctrl_pkg::seq_t s_ff, nxt_s;
  mem_ctrl_pkg::pin_t p_ff, nxt_p;

  always_comb
  begin
    logic [3:0]  nib;
    logic [28:0] off;
    logic        go, finish, beat_end, lead, edac, act, in_data, cs_on;
    logic [2:0]  nb;
    nib      = req_addr[31:28];
    off      = req_addr[28:0] >> (`MC_BANK_MIN_SHIFT + {1'b0, cfg_ff.ram_bank_size});
    go       = 1'b0;
    finish   = 1'b0;
    beat_end = 1'b0;
    edac     = 1'b0;
    lead     = 1'b0;
    act      = 1'b0;
    in_data  = 1'b0;
    cs_on    = 1'b0;
    nb       = `MC_NO_BEAT;
    nxt_s       = s_ff;
    nxt_s.done  = 1'b0;
    nxt_s.trap  = 1'b0;
    nxt_s.sdram = 1'b0;
    case (s_ff.state)
      mem_ctrl_pkg::ST_IDLE:
        if (req_valid)
        begin
          nxt_s.addr   = req_addr;
          nxt_s.wr     = req_write;
          nxt_s.fetch  = req_fetch;
          nxt_s.be     = req_byte_en;
          nxt_s.wdata  = req_wdata;
          nxt_s.wcbits = req_check_bits;
          nxt_s.rmw    = 1'b0;
          nxt_s.bank   = `MC_BANK_NONE;
          nxt_s.code   = mem_ctrl_pkg::fault_code(req_write, req_fetch);
          if (cfg_ff.sdram_enable && nib >= `MC_NIB_DYN_FIRST && nib <= `MC_NIB_DYN_LAST)
            nxt_s.sdram = 1'b1;
          else if (nib == `MC_NIB_BOOT0 || nib == `MC_NIB_BOOT1)
          begin
            nxt_s.area   = (nib == `MC_NIB_BOOT1) ? mem_ctrl_pkg::AREA_BOOT1 : mem_ctrl_pkg::AREA_BOOT0;
            nxt_s.narrow = cfg_ff.boot_width_8;
            nxt_s.rdy_ok = cfg_ff.boot_ready_enable;
            edac         = cfg_ff.boot_edac_enable;
            nxt_s.trap   = req_write && !cfg_ff.boot_write_enable;
            go           = !nxt_s.trap;
          end
          else if (nib == `MC_NIB_IO_LO || nib == `MC_NIB_IO_HI)
          begin
            nxt_s.area   = mem_ctrl_pkg::AREA_IO;
            nxt_s.narrow = cfg_ff.io_width_8;
            nxt_s.rdy_ok = cfg_ff.io_ready_enable;
            nxt_s.trap   = !cfg_ff.io_enable;
            go           = cfg_ff.io_enable;
          end
          else if (nib == `MC_NIB_BANK4 || ((nib == `MC_NIB_RAM_LO || nib == `MC_NIB_RAM_HI) && off < 29'h4))
          begin
            // bank 4 is tested first so it wins any overlap with banks 2 and 3
            nxt_s.area   = mem_ctrl_pkg::AREA_RAM;
            nxt_s.bank   = (nib == `MC_NIB_BANK4) ? `MC_BANK_FOUR : off[2:0];
            nxt_s.narrow = cfg_ff.ram_width_8;
            nxt_s.rdy_ok = (nib == `MC_NIB_BANK4) && cfg_ff.ram_ready_enable;
            edac         = cfg_ff.ram_edac_enable;
            nxt_s.rmw    = req_write && req_byte_en != `MC_FULL_WORD
                           && (cfg_ff.ram_edac_enable || cfg_ff.ram_rmw);
            nxt_s.wr     = req_write && !nxt_s.rmw;
            go           = 1'b1;
          end
          else
            nxt_s.trap = 1'b1;
          if (go)
          begin
            nxt_s.mask = mem_ctrl_pkg::beat_mask(nxt_s.narrow, edac,
                           nxt_s.area == mem_ctrl_pkg::AREA_IO || (nxt_s.wr && !edac), req_byte_en);
            nxt_s.beat = mem_ctrl_pkg::next_beat(nxt_s.mask, 3'h0);
          end
        end
      mem_ctrl_pkg::ST_LEAD:
        nxt_s.state = mem_ctrl_pkg::ST_DATA;
      mem_ctrl_pkg::ST_DATA:
        if (s_ff.cnt != 6'h00)
          nxt_s.cnt = s_ff.cnt - 6'h01;
        else if (s_ff.rdy_ok && !rdy_ff)
          nxt_s.state = mem_ctrl_pkg::ST_READY;
        else
          finish = 1'b1;
      mem_ctrl_pkg::ST_READY:
        finish = rdy_ff;
      mem_ctrl_pkg::ST_TRAIL:
        beat_end = 1'b1;
      default:
        nxt_s.state = mem_ctrl_pkg::ST_IDLE;
    endcase

    if (finish)
    begin
      if (!s_ff.wr && s_ff.narrow && s_ff.beat == `MC_CHECK_BEAT)
        nxt_s.cbits = data_in[31:24];
      else if (!s_ff.wr && s_ff.narrow)
        nxt_s.rdata[8'(31 - 8 * s_ff.beat[1:0]) -: 8] = data_in[31:24];
      else if (!s_ff.wr)
      begin
        nxt_s.rdata = data_in;
        nxt_s.cbits = check_bit_lines_in;
      end
      if (s_ff.wr || s_ff.area == mem_ctrl_pkg::AREA_IO)
        nxt_s.state = mem_ctrl_pkg::ST_TRAIL;
      else
        beat_end = 1'b1;
    end

    if (beat_end)
    begin
      nb = mem_ctrl_pkg::next_beat(s_ff.mask, s_ff.beat + 3'h1);
      if (nb != `MC_NO_BEAT)
      begin
        nxt_s.beat = nb;
        go         = 1'b1;
      end
      else if (s_ff.rmw)
      begin
        // read half done: merge the store lanes, then write the whole word back
        nxt_s.rmw = 1'b0;
        nxt_s.wr  = 1'b1;
        for (int i = 0; i < 4; i++)
          nxt_s.wdata[8 * i +: 8] = s_ff.be[i] ? s_ff.wdata[8 * i +: 8] : nxt_s.rdata[8 * i +: 8];
        nxt_s.mask = mem_ctrl_pkg::beat_mask(s_ff.narrow, cfg_ff.ram_edac_enable, 1'b0, `MC_FULL_WORD);
        nxt_s.beat = mem_ctrl_pkg::next_beat(nxt_s.mask, 3'h0);
        go         = 1'b1;
      end
      else
      begin
        nxt_s.done  = 1'b1;
        nxt_s.state = mem_ctrl_pkg::ST_IDLE;
      end
    end

    if (go)
    begin
      lead        = nxt_s.wr || nxt_s.area == mem_ctrl_pkg::AREA_IO;
      nxt_s.cnt   = mem_ctrl_pkg::data_len(nxt_s.area, nxt_s.wr, nxt_s.bank, cfg_ff);
      nxt_s.state = lead ? mem_ctrl_pkg::ST_LEAD : mem_ctrl_pkg::ST_DATA;
    end
    nxt_s.ready = nxt_s.state == mem_ctrl_pkg::ST_IDLE && !nxt_s.trap && !nxt_s.sdram;

    // pins follow the next state so every pin comes from a flop
    act     = nxt_s.state != mem_ctrl_pkg::ST_IDLE;
    in_data = nxt_s.state == mem_ctrl_pkg::ST_DATA || nxt_s.state == mem_ctrl_pkg::ST_READY;
    cs_on   = act && !(nxt_s.area == mem_ctrl_pkg::AREA_IO && !nxt_s.wr
                       && nxt_s.state == mem_ctrl_pkg::ST_LEAD);
    nxt_p           = p_ff;
    nxt_p.addr      = nxt_s.narrow ? {nxt_s.addr[27:2], nxt_s.beat[2] ? 2'h0 : nxt_s.beat[1:0]}
                                   : nxt_s.addr[27:0];
    nxt_p.data      = nxt_s.narrow ? {(nxt_s.beat == `MC_CHECK_BEAT) ? nxt_s.wcbits
                                      : mem_ctrl_pkg::lane_byte(nxt_s.wdata, nxt_s.beat[1:0]), 24'h00_0000}
                                   : nxt_s.wdata;
    nxt_p.data_oe   = act && nxt_s.wr;
    nxt_p.cb        = nxt_s.wcbits;
    nxt_p.cb_oe     = act && nxt_s.wr && !nxt_s.narrow && nxt_s.area != mem_ctrl_pkg::AREA_IO;
    nxt_p.boot_cs_n = ~({nxt_s.area == mem_ctrl_pkg::AREA_BOOT1,
                         nxt_s.area == mem_ctrl_pkg::AREA_BOOT0} & {2{cs_on}});
    nxt_p.io_cs_n   = !(cs_on && nxt_s.area == mem_ctrl_pkg::AREA_IO);
    nxt_p.bank_cs_n = ~((cs_on && nxt_s.area == mem_ctrl_pkg::AREA_RAM) ? 5'h01 << nxt_s.bank : 5'h00);
    nxt_p.bank_oe_n = ~((in_data && !nxt_s.wr && nxt_s.area == mem_ctrl_pkg::AREA_RAM
                         && nxt_s.bank != `MC_BANK_FOUR) ? 4'h1 << nxt_s.bank[1:0] : 4'h0);
    nxt_p.oe_n      = !(in_data && !nxt_s.wr);
    nxt_p.rd        = act && !nxt_s.wr;
    nxt_p.we_n      = !(in_data && nxt_s.wr);
    nxt_p.lane_n    = ~((in_data && nxt_s.wr && nxt_s.area != mem_ctrl_pkg::AREA_IO)
                        ? (nxt_s.narrow ? `MC_NARROW_LANE : nxt_s.be) : 4'h0);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_ff       <= '0;
      s_ff.state <= mem_ctrl_pkg::ST_IDLE;
      s_ff.ready <= 1'b1;
      p_ff       <= '1;
      p_ff.addr  <= '0;
      p_ff.data  <= '0;
      p_ff.cb    <= '0;
      p_ff.data_oe <= 1'b0;
      p_ff.cb_oe <= 1'b0;
      p_ff.rd    <= 1'b0;
    end
    else
    begin
      s_ff <= nxt_s;
      p_ff <= nxt_p;
    end
  end

  // =====================================================
  // outputs
  assign req_ready                   = s_ff.ready;
  assign resp_done                   = s_ff.done;
  assign resp_trap                   = s_ff.trap;
  assign resp_trap_code              = s_ff.code;
  assign resp_rdata                  = s_ff.rdata;
  assign resp_check_bits             = s_ff.cbits;
  assign sdram_request               = s_ff.sdram;
  assign addr_out                    = p_ff.addr;
  assign data_out                    = p_ff.data;
  assign data_oe                     = p_ff.data_oe;
  assign check_bit_lines_out         = p_ff.cb;
  assign check_bit_lines_oe          = p_ff.cb_oe;
  assign boot_chip_select_n          = p_ff.boot_cs_n;
  assign io_chip_select_n            = p_ff.io_cs_n;
  assign static_bank_select_n        = p_ff.bank_cs_n;
  assign static_bank_output_enable_n = p_ff.bank_oe_n;
  assign output_enable_n             = p_ff.oe_n;
  assign read_strobe                 = p_ff.rd;
  assign write_strobe_n              = p_ff.we_n;
  assign byte_lane_write_strobe_n    = p_ff.lane_n;

endmodule

`default_nettype wire

// >>> tb/mem_ctrl_checker.sv
// checker: refusals, decode priority and write framing at the pins
// assumes one clock, async active-low reset; bound to the top module
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_checker
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        cfg_load,
  input wire logic        cfg_boot_write_enable,
  input wire logic        cfg_io_enable,
  input wire logic [3:0]  cfg_ram_bank_size,
  input wire logic        cfg_sdram_enable,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [31:0] req_addr,
  input wire logic        req_write,
  input wire logic        req_fetch,
  input wire logic        resp_done,
  input wire logic        resp_trap,
  input wire logic [7:0]  resp_trap_code,
  input wire logic        sdram_request,
  input wire logic [27:0] addr_out,
  input wire logic        data_oe,
  input wire logic        io_chip_select_n,
  input wire logic [4:0]  static_bank_select_n,
  input wire logic [3:0]  static_bank_output_enable_n,
  input wire logic        write_strobe_n,
  input wire logic [3:0]  byte_lane_write_strobe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // =====================================================
  // config copy, so refusals can be predicted
  logic [6:0] cfg_ff;
  logic       take;
  assign take = req_valid && req_ready;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_ff <= 7'h00;
    else if (cfg_load)
      cfg_ff <= {cfg_boot_write_enable, cfg_io_enable, cfg_sdram_enable, cfg_ram_bank_size};
  end
  sequence s_addr_held;
    $stable(addr_out) && !req_ready;
  endsequence
  // =====================================================
  // properties
  chk_boot_write_trap:
    assert property (take && req_write && req_addr[31:29] == 3'h0 && !cfg_ff[6] |=> resp_trap
      && resp_trap_code == 8'h2b) else $error("boot write not refused");
  chk_io_off_trap:
    assert property (take && req_addr[31:29] == 3'h1 && !cfg_ff[5] |=> resp_trap
      && resp_trap_code == ($past(req_write) ? 8'h2b : $past(req_fetch) ? 8'h01 : 8'h09))
      else $error("disabled io access not refused");
  chk_dram_owns_top:
    assert property (take && cfg_ff[4] && req_addr[31:29] == 3'h3 |=> sdram_request && &static_bank_select_n)
      else $error("dynamic area not handed over");
  chk_bank_four_wins:
    assert property (cfg_ff[3:0] == 4'hf |-> &static_bank_select_n[3:2])
      else $error("bank 2 or 3 selected at full size");
  chk_oe_own_bank:
    assert property ((~static_bank_output_enable_n & static_bank_select_n[3:0]) == 4'h0)
      else $error("output enable without its bank");
  chk_hold_keeps_addr:
    assert property ($rose(write_strobe_n) |-> s_addr_held and !resp_done)
      else $error("write hold cycle missing");
  chk_io_select_late:
    assert property ($fell(io_chip_select_n) && !data_oe |-> s_addr_held)
      else $error("io read select not delayed");
  chk_wait_holds_pins:
    assert property (!write_strobe_n && !$past(write_strobe_n) |-> $stable(addr_out)
      && $stable(byte_lane_write_strobe_n)) else $error("pins moved during write wait");
endmodule
bind prom_io_sram_memory_controller mem_ctrl_checker chk (.*);
`default_nettype wire

// >>> tb/sram_partner.sv
// model of the asynchronous memory and i/o parts on the external bus
// assumes 32-bit parts; one small word array serves every area
`timescale 1ns/1ps
`default_nettype none
module sram_partner
(
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic [27:0] addr_out,
  input  wire logic [31:0] data_out,
  input  wire logic        output_enable_n,
  input  wire logic        write_strobe_n,
  input  wire logic [3:0]  byte_lane_write_strobe_n,
  output logic [31:0]      data_in,
  output logic [7:0]       check_bit_lines_in,
  output logic             external_ready_n
);
  logic [31:0] mem [0:255];
  logic [31:0] last_ff;
  initial
  begin
    last_ff = 32'h0000_0000;
    for (int i = 0; i < 256; i++)
      mem[i] = i;
  end
  // released bus toggles, so a late sample never sees stale data
  assign data_in = output_enable_n ? ~last_ff : mem[addr_out[9:2]];
  assign check_bit_lines_in = ~data_in[7:0];
  assign external_ready_n = stall;
  always @(posedge clk)
  begin
    last_ff <= data_in;
    if (!write_strobe_n)
      for (int i = 0; i < 4; i++)
        if (!byte_lane_write_strobe_n[i] || &byte_lane_write_strobe_n)
          mem[addr_out[9:2]][8*i +: 8] <= data_out[8*i +: 8];
  end
endmodule
`default_nettype wire

// >>> tb/prom_io_sram_memory_controller_test.sv
// bench: refusals, timing per area, decode, byte lanes, ready stretch
// assumes sram_partner on the far side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module prom_io_sram_memory_controller_test;
  mem_ctrl_pkg::cfg_t cfg;
  logic        clk, reset_n, cfg_load, req_valid, req_write, req_fetch, stall, p;
  logic [31:0] req_addr, req_wdata, data_in, data_out, resp_rdata;
  logic [3:0]  req_byte_en, blws_n, boe_n;
  logic        req_ready, resp_done, resp_trap, sdram_request, oe_n, ws_n, io_cs_n, ext_rdy_n;
  logic [7:0]  resp_trap_code, cb_in, sel_seen;
  logic [27:0] addr_out;
  logic [1:0]  boot_cs_n;
  logic [4:0]  bank_cs_n;
  logic [2:0]  outcome;
  int          lat, n_fall, err_count, n_checks, cycles, w, r;
  assign outcome = {resp_done, resp_trap, sdram_request};
  prom_io_sram_memory_controller uut
  (
    .*, .cfg_boot_read_ws(cfg.boot_read_ws),
    .cfg_boot_write_ws(cfg.boot_write_ws), .cfg_boot_write_enable(cfg.boot_write_enable),
    .cfg_boot_width_8(cfg.boot_width_8), .boot_edac_enable(cfg.boot_edac_enable),
    .cfg_boot_ready_enable(cfg.boot_ready_enable), .cfg_io_enable(cfg.io_enable), .cfg_io_width_8(cfg.io_width_8),
    .cfg_io_ws(cfg.io_ws), .cfg_io_ready_enable(cfg.io_ready_enable), .cfg_ram_width_8(cfg.ram_width_8),
    .cfg_ram_bank_size(cfg.ram_bank_size), .cfg_ram_read_ws(cfg.ram_read_ws), .cfg_ram_write_ws(cfg.ram_write_ws),
    .cfg_ram_rmw(cfg.ram_rmw), .ram_edac_enable(cfg.ram_edac_enable), .cfg_ram_ready_enable(cfg.ram_ready_enable),
    .cfg_sdram_enable(cfg.sdram_enable), .req_check_bits(8'h00), .resp_check_bits(),
    .data_oe(), .check_bit_lines_in(cb_in), .check_bit_lines_out(),
    .check_bit_lines_oe(), .boot_chip_select_n(boot_cs_n), .io_chip_select_n(io_cs_n),
    .static_bank_select_n(bank_cs_n), .static_bank_output_enable_n(boe_n), .output_enable_n(oe_n),
    .read_strobe(), .write_strobe_n(ws_n), .byte_lane_write_strobe_n(blws_n), .external_ready_n(ext_rdy_n)
  );
  sram_partner far_side
  (
    .*, .output_enable_n(oe_n), .write_strobe_n(ws_n), .byte_lane_write_strobe_n(blws_n),
    .check_bit_lines_in(cb_in), .external_ready_n(ext_rdy_n)
  );
  // =====================================================
  // clock, watchdog, shared tasks
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_count++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // waits one edge first, so the request meets req_ready high
  task automatic access(input logic [31:0] a, input logic wr, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    #2;
    {req_valid, req_addr, req_write, req_byte_en, req_wdata} = {1'b1, a, wr, be, d};
    @(posedge clk);
    #2;
    req_valid = 0;
    lat = 1;
    n_fall = 0;
    sel_seen = 8'h00;
    while (outcome === 3'b000 && lat < 300)
    begin
      @(posedge clk);
      #2;
      lat++;
      sel_seen |= ~{boot_cs_n, io_cs_n, bank_cs_n};
      n_fall += (p && !ws_n);
      p = ws_n;
    end
  endtask
  task automatic load;
    @(posedge clk);
    #2;
    cfg_load = 1;
    @(posedge clk);
    #2;
    cfg_load = 0;
  endtask
  // =====================================================
  // main sequence
  initial
  begin
    cfg = '0;
    {reset_n, cfg_load, req_valid, req_write, req_fetch, stall, req_addr, req_wdata, req_byte_en} = '0;
    p = 1;
    repeat (3) @(posedge clk);
    #2;
    reset_n = 1;
    access(32'h1000_0000, 0, 4'hf, 0);
    check("boot read cycles", 33, lat);
    check("boot select", 8'h80, sel_seen);
    access(32'h0000_0030, 1, 4'hf, 1);
    check("boot write refusal", 32'h0000_022b, {outcome, resp_trap_code});
    for (int k = 0; k < 3; k++)
    begin
      req_fetch = (k == 0);
      access(32'h2000_0000, k == 2, 4'hf, 0);
      check("io off code", k == 0 ? 8'h01 : k == 1 ? 8'h09 : 8'h2b, resp_trap_code);
    end
    req_fetch = 0;
    cfg.io_enable = 1;
    cfg.boot_write_enable = 1;
    for (int i = 0; i < 3; i++)
    begin
      w = (i == 2) ? 15 : 3 * i;
      r = (w > 3) ? 3 : w;
      {cfg.boot_read_ws, cfg.boot_write_ws, cfg.io_ws} = {3{w[3:0]}};
      {cfg.ram_read_ws, cfg.ram_write_ws} = {2{r[1:0]}};
      load;
      access(32'h4000_0010, 1, 4'hf, 32'h1234_5670 + w);
      check("ram write cycles", 4 + r, lat);
      access(32'h4000_0010, 0, 4'hf, 0);
      check("ram read cycles", 3 + r, lat);
      check("ram read data", 32'h1234_5670 + w, resp_rdata);
      access(32'h2000_0020, 1, 4'hf, 32'hcafe_0000 + w);
      check("io write cycles", 4 + w, lat);
      access(32'h3000_0020, 0, 4'hf, 0);
      check("io read cycles", 5 + w, lat);
      check("io alias data", 32'hcafe_0000 + w, resp_rdata);
      access(32'h0000_0030, 1, 4'hf, 32'h5a5a_0000 + w);
      check("boot write cycles", 4 + 2 * w, lat);
      access(32'h0000_0030, 0, 4'hf, 0);
      check("boot read data", 32'h5a5a_0000 + w, resp_rdata);
    end
    access(32'h4000_0010, 1, 4'h3, 32'hffff_abcd);
    access(32'h4000_0010, 0, 4'hf, 0);
    check("lane merge", 32'h1234_abcd, resp_rdata);
    for (int i = 0; i < 4; i++)
    begin
      access(32'h4000_0000 + i * 32'h2000, 0, 4'hf, 0);
      check("bank select", 8'h01 << i, sel_seen);
    end
    access(32'h4000_8000, 0, 4'hf, 0);
    check("beyond bank 3", 3'b010, outcome);
    cfg.ram_bank_size = 4'hf;
    cfg.io_ready_enable = 1;
    cfg.ram_ready_enable = 1;
    load;
    access(32'h6000_0000, 0, 4'hf, 0);
    check("bank four wins", 8'h10, sel_seen);
    stall = 1;
    access(32'h4000_0010, 0, 4'hf, 0);
    check("bank 0 ignores ready", 6, lat);
    fork
      begin
        repeat (40) @(posedge clk);
        #2;
        stall = 0;
      end
    join_none
    access(32'h2000_0020, 0, 4'hf, 0);
    check("io held by ready", 1, lat > 30);
    cfg.sdram_enable = 1;
    cfg.boot_width_8 = 1;
    cfg.ram_width_8 = 1;
    load;
    access(32'h7000_0000, 0, 4'hf, 0);
    check("dynamic handover", 3'b001, outcome);
    access(32'h0000_0034, 1, 4'h5, 0);
    check("narrow boot strobes", 2, n_fall);
    access(32'h4000_0014, 1, 4'hf, 0);
    check("narrow ram strobes", 4, n_fall);
    end_of_test;
  end
endmodule
`default_nettype wire
